/* File: scfg_regs.sv */
// System configuration register bank with pin allocation and echo routing
`timescale 1ns/1ps
`default_nettype none
module scfg_regs
    import scfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic monitor_strap_i,
    input wire logic active_mode_i,
    input wire logic dev_env_i,
    input wire logic [scfg_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic shadow_wr_o,
    output logic [7:0] shadow_data_o,
    input wire logic clock_output_pin_is_output_i,
    input wire logic core_clk_en_i,
    input wire logic slow_clk_i,
    output logic clock_out_o,
    output logic io_expansion_o,
    output logic mem_expansion_o,
    output scfg_pkg::scfg_mem_width_t mem_width_o,
    output logic dev_alloc_o,
    input wire logic [1:0] wake_is_gpio_i,
    input wire logic [1:0] wake_pin_i,
    output logic [1:0] wake_open_o,
    output logic [1:0] wake_to_irq_o,
    input wire logic [scfg_pkg::ECHO_PAIRS-1:0] alt_in_sel_i,
    output logic [scfg_pkg::ECHO_PAIRS-1:0] alt_irq_en_o,
    input wire logic [scfg_pkg::ECHO_PAIRS-1:0] echo_out_gpio_i,
    input wire logic [scfg_pkg::ECHO_PAIRS-1:0] echo_in_pin_i,
    output logic [scfg_pkg::ECHO_PAIRS-1:0] echo_valid_o,
    output logic [scfg_pkg::ECHO_PAIRS-1:0] echo_val_o
);
    import scfg_pkg::*;

    logic [7:0] module_config_r, module_config_nxt, ext_irq_config_r, ext_irq_config_nxt;
    logic [7:0] ee1_r, ee1_nxt, ee2_r, ee2_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic shw_r, shw_nxt;
    logic [7:0] shd_r, shd_nxt;
    logic strap_seen_r, strap_seen_nxt;
    logic strap_meta_r, strap_sync_r;
    logic [1:0] wk_meta_r, wk_sync_r, wk_out_r, wk_out_nxt;
    logic clk_meta_r, clk_sync_r, clko_r, clko_nxt;
    logic [1:0] clksel;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    assign clksel = module_config_r[BIT_CLKSEL_HI:BIT_CLKSEL_LO];

    always_comb begin
        module_config_nxt = module_config_r;
        ext_irq_config_nxt = ext_irq_config_r;
        ee1_nxt = ee1_r;
        ee2_nxt = ee2_r;
        shw_nxt = 1'b0;
        shd_nxt = shd_r;
        strap_seen_nxt = 1'b1;
        rdata_nxt = rdata_r;
        // Monitor flag captured on the first cycle after reset release
        if (!strap_seen_r) begin
            module_config_nxt[BIT_MONITOR] = strap_sync_r;
        end
        if (wr_i) begin
            if (hit(addr_i, ADDR_MODULE_CONFIG) && active_mode_i) begin
                module_config_nxt = (wdata_i & MODULE_CONFIG_RW_MASK)
                         | {module_config_r[BIT_MONITOR] & wdata_i[BIT_MONITOR],
                            7'h00};
            end
            if (hit(addr_i, ADDR_EXT_IRQ_CONFIG)) begin
                ext_irq_config_nxt = wdata_i & EXT_IRQ_CONFIG_RW_MASK;
            end
            if (hit(addr_i, ADDR_ECHO_FIRST)) begin
                ee1_nxt = wdata_i & ECHO_RW_MASK;
            end
            if (hit(addr_i, ADDR_ECHO_SECOND)) begin
                ee2_nxt = wdata_i & ECHO_RW_MASK;
            end
            // Shadow is write only: forwarded to the development system
            if (hit(addr_i, ADDR_MODULE_CONFIG_SHADOW)) begin
                shw_nxt = 1'b1;
                shd_nxt = wdata_i;
            end
        end
        if (rd_i) begin
            if (hit(addr_i, ADDR_MODULE_CONFIG)) begin
                rdata_nxt = module_config_r;
            end else if (hit(addr_i, ADDR_EXT_IRQ_CONFIG)) begin
                rdata_nxt = ext_irq_config_r;
            end else if (hit(addr_i, ADDR_ECHO_FIRST)) begin
                rdata_nxt = ee1_r;
            end else if (hit(addr_i, ADDR_ECHO_SECOND)) begin
                rdata_nxt = ee2_r;
            end else begin
                rdata_nxt = RESET_ZERO;
            end
        end
        // Wake inputs act only in GPIO use and only when opened
        wk_out_nxt = wk_sync_r & ext_irq_config_r[BIT_WAKE_B:BIT_WAKE_A]
                   & wake_is_gpio_i;
        case (clksel)
            CLKSEL_CORE: clko_nxt = core_clk_en_i;
            CLKSEL_SLOW: clko_nxt = clk_sync_r;
            default: clko_nxt = 1'b0;
        endcase
        if (!clock_output_pin_is_output_i) begin
            clko_nxt = 1'b0;
        end
    end

    // Strap pin synchroniser runs through reset so it has settled at release
    always_ff @(posedge clk_i) begin
        strap_meta_r <= monitor_strap_i;
        strap_sync_r <= strap_meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            module_config_r <= RESET_ZERO;
            ext_irq_config_r <= RESET_ZERO;
            ee1_r <= RESET_ZERO;
            ee2_r <= RESET_ZERO;
            rdata_r <= RESET_ZERO;
            shw_r <= 1'b0;
            shd_r <= RESET_ZERO;
            strap_seen_r <= 1'b0;
            wk_meta_r <= 2'h0;
            wk_sync_r <= 2'h0;
            wk_out_r <= 2'h0;
            clk_meta_r <= 1'b0;
            clk_sync_r <= 1'b0;
            clko_r <= 1'b0;
        end else begin
            module_config_r <= module_config_nxt;
            ext_irq_config_r <= ext_irq_config_nxt;
            ee1_r <= ee1_nxt;
            ee2_r <= ee2_nxt;
            rdata_r <= rdata_nxt;
            shw_r <= shw_nxt;
            shd_r <= shd_nxt;
            strap_seen_r <= strap_seen_nxt;
            wk_meta_r <= wake_pin_i;
            wk_sync_r <= wk_meta_r;
            wk_out_r <= wk_out_nxt;
            clk_meta_r <= slow_clk_i;
            clk_sync_r <= clk_meta_r;
            clko_r <= clko_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign shadow_wr_o = shw_r;
    assign shadow_data_o = shd_r;
    assign clock_out_o = clko_r;
    // Development environment owns the pins regardless of the fields
    assign dev_alloc_o = dev_env_i;
    assign io_expansion_o = dev_env_i | module_config_r[BIT_IO_EXP];
    assign mem_expansion_o = dev_env_i | module_config_r[BIT_MEM_EXP];
    assign mem_width_o = scfg_mem_width_t'(dev_env_i |
        (module_config_r[BIT_MEM_EXP] & module_config_r[BIT_WIDE_MEM]));
    assign wake_open_o = ext_irq_config_r[BIT_WAKE_B:BIT_WAKE_A];
    assign wake_to_irq_o = wk_out_r;
    assign alt_irq_en_o = alt_in_sel_i;

    scfg_echo #(
        .PAIRS(ECHO_PAIRS)
    ) u_echo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .echo_en_i({ee2_r[ECHO_PER_REG-1:0], ee1_r[ECHO_PER_REG-1:0]}),
        .out_is_gpio_i(echo_out_gpio_i),
        .wake_in_i(echo_in_pin_i),
        .echo_valid_o(echo_valid_o),
        .echo_val_o(echo_val_o)
    );

    mon_noset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(strap_seen_r) && !$past(module_config_r[BIT_MONITOR])
        |-> !module_config_r[BIT_MONITOR])
        else $error("monitor flag set again");
    idle_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        strap_seen_r && !active_mode_i |=> $stable(module_config_r))
        else $error("module config changed in idle");
    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        module_config_r[6:5] == 2'h0 && ext_irq_config_r[7:2] == 6'h00
        && ee1_r[7:5] == 3'h0 && ee2_r[7:5] == 3'h0)
        else $error("reserved bit set");
    rst_value_a: assert property (@(posedge clk_i)
        !resetn_i |=> module_config_r == RESET_ZERO && ext_irq_config_r == RESET_ZERO)
        else $error("bad reset value");
    echo_rst_a: assert property (@(posedge clk_i)
        !resetn_i |=> ee1_r == RESET_ZERO && ee2_r == RESET_ZERO)
        else $error("echo enables not cleared");
    dev_alloc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dev_env_i |-> io_expansion_o && mem_expansion_o)
        else $error("pins not allocated in development");
    wake_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !ext_irq_config_r[BIT_WAKE_A] ##1 !ext_irq_config_r[BIT_WAKE_A]
        |-> !wake_to_irq_o[BIT_WAKE_A])
        else $error("blocked wake input passed");
    clk_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(clock_output_pin_is_output_i) |-> !clock_out_o)
        else $error("clock out driven while not output");
endmodule : scfg_regs
`default_nettype wire

/* File: scfg_pkg.sv */
// Package: register map, field positions and reset values of the config bank
package scfg_pkg;
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] ADDR_EXT_IRQ_CONFIG = 24'h00FF00;
    localparam logic [ADDR_W-1:0] ADDR_ECHO_FIRST = 24'h00FF02;
    localparam logic [ADDR_W-1:0] ADDR_ECHO_SECOND = 24'h00FF04;
    localparam logic [ADDR_W-1:0] ADDR_MODULE_CONFIG = 24'h00FF10;
    localparam logic [ADDR_W-1:0] ADDR_MODULE_CONFIG_SHADOW = 24'h00FBFE;
    localparam int BIT_IO_EXP = 0;
    localparam int BIT_MEM_EXP = 1;
    localparam int BIT_WIDE_MEM = 2;
    localparam int BIT_CLKSEL_LO = 3;
    localparam int BIT_CLKSEL_HI = 4;
    localparam int BIT_MONITOR = 7;
    localparam int BIT_WAKE_A = 0;
    localparam int BIT_WAKE_B = 1;
    localparam logic [7:0] MODULE_CONFIG_RW_MASK = 8'h1F;
    localparam logic [7:0] EXT_IRQ_CONFIG_RW_MASK = 8'h03;
    localparam logic [7:0] ECHO_RW_MASK = 8'h1F;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [1:0] CLKSEL_CORE = 2'h1;
    localparam logic [1:0] CLKSEL_SLOW = 2'h2;
    localparam int ECHO_PAIRS = 10;
    localparam int ECHO_PER_REG = 5;
    // Bus width encoding of the expansion memory
    typedef enum logic [0:0] {
        SCFG_MEM_8 = 1'b0,
        SCFG_MEM_16 = 1'b1
    } scfg_mem_width_t;
endpackage : scfg_pkg

/* File: scfg_echo.sv */
// Fixed echo routing of wake inputs to paired output ports
`timescale 1ns/1ps
`default_nettype none
module scfg_echo
    import scfg_pkg::*;
#(
    parameter int PAIRS = ECHO_PAIRS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [PAIRS-1:0] echo_en_i,
    input wire logic [PAIRS-1:0] out_is_gpio_i,
    input wire logic [PAIRS-1:0] wake_in_i,
    output logic [PAIRS-1:0] echo_valid_o,
    output logic [PAIRS-1:0] echo_val_o
);
    logic [PAIRS-1:0] meta_r, sync_r, val_r, vld_r;
    logic [PAIRS-1:0] val_nxt, vld_nxt;

    always_comb begin
        vld_nxt = echo_en_i & out_is_gpio_i;
        val_nxt = sync_r & vld_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_r <= '0;
            sync_r <= '0;
            val_r <= '0;
            vld_r <= '0;
        end else begin
            meta_r <= wake_in_i;
            sync_r <= meta_r;
            val_r <= val_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign echo_valid_o = vld_r;
    assign echo_val_o = val_r;

    echo_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (echo_val_o & ~$past(echo_en_i & out_is_gpio_i)) == '0)
        else $error("echo driven while disabled");
endmodule : scfg_echo
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the system configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scfg_pkg::*;
    typedef struct {
        logic [23:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } scfg_row_t;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic monitor_strap_i = 1'b1;
    logic active_mode_i = 1'b1;
    logic dev_env_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic clock_output_pin_is_output_i = 1'b1;
    logic core_clk_en_i = 1'b0;
    logic slow_clk_i = 1'b0;
    logic [1:0] wake_is_gpio_i = 2'h3;
    logic [1:0] wake_pin_i = 2'h0;
    logic [ECHO_PAIRS-1:0] alt_in_sel_i = '0;
    logic [ECHO_PAIRS-1:0] echo_out_gpio_i = '1;
    logic [ECHO_PAIRS-1:0] echo_in_pin_i = '0;
    logic [7:0] rdata_o, shadow_data_o;
    logic shadow_wr_o, clock_out_o, io_expansion_o, mem_expansion_o;
    logic dev_alloc_o;
    scfg_mem_width_t mem_width_o;
    logic [1:0] wake_open_o, wake_to_irq_o;
    logic [ECHO_PAIRS-1:0] alt_irq_en_o, echo_valid_o, echo_val_o;
    logic [7:0] v;
    int mismatches = 0;
    int checked = 0;
    // Ordinary accesses: write a value, read back the masked result
    // Module config rows keep its reserved bits at zero
    scfg_row_t rows[7] = '{
        '{24'h00FF10, 8'h9F, 8'h9F}, '{24'h00FF10, 8'h1F, 8'h1F},
        '{24'h00FF10, 8'h9F, 8'h1F}, '{24'h00FF00, 8'hFF, 8'h03},
        '{24'h00FF02, 8'hFF, 8'h1F}, '{24'h00FF04, 8'h15, 8'h15},
        '{24'h00FF06, 8'hAA, 8'h00}};

    scfg_regs u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .monitor_strap_i(monitor_strap_i), .active_mode_i(active_mode_i),
        .dev_env_i(dev_env_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .shadow_wr_o(shadow_wr_o),
        .shadow_data_o(shadow_data_o),
        .clock_output_pin_is_output_i(clock_output_pin_is_output_i),
        .core_clk_en_i(core_clk_en_i), .slow_clk_i(slow_clk_i),
        .clock_out_o(clock_out_o), .io_expansion_o(io_expansion_o),
        .mem_expansion_o(mem_expansion_o), .mem_width_o(mem_width_o),
        .dev_alloc_o(dev_alloc_o), .wake_is_gpio_i(wake_is_gpio_i),
        .wake_pin_i(wake_pin_i), .wake_open_o(wake_open_o),
        .wake_to_irq_o(wake_to_irq_o), .alt_in_sel_i(alt_in_sel_i),
        .alt_irq_en_o(alt_irq_en_o), .echo_out_gpio_i(echo_out_gpio_i),
        .echo_in_pin_i(echo_in_pin_i), .echo_valid_o(echo_valid_o),
        .echo_val_o(echo_val_o));

    always #2.5 clk_i = ~clk_i;

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask : wr

    // Module config write always followed by the same value to the shadow
    task automatic wr_mc(input logic [7:0] d);
        wr(ADDR_MODULE_CONFIG, d);
        wr(ADDR_MODULE_CONFIG_SHADOW, d);
    endtask : wr_mc

    task automatic rd(input logic [23:0] a, output logic [7:0] q);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        q = rdata_o;
    endtask : rd

    task automatic cmp(input string n, input logic [9:0] e,
                       input logic [9:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic summarize;
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic do_reset(input logic strap);
        monitor_strap_i = strap;
        resetn_i = 1'b0;
        cyc(6);
        resetn_i = 1'b1;
        cyc(2);
    endtask : do_reset

    // Watchdog sized well above the expected run length
    initial begin
        #20000;
        mismatches++;
        summarize();
    end

    initial begin
        do_reset(1'b1);
        rd(ADDR_MODULE_CONFIG, v);
        cmp("module_config_rst", 10'h080, {2'h0, v});
        wr(ADDR_MODULE_CONFIG_SHADOW, v);
        cmp("shadow_cp", 10'h080, {2'h0, shadow_data_o});
        rd(ADDR_EXT_IRQ_CONFIG, v);
        cmp("ext_irq_config_rst", 10'h0, {2'h0, v});
        rd(ADDR_ECHO_FIRST, v);
        cmp("echo1_rst", 10'h0, {2'h0, v});
        rd(ADDR_ECHO_SECOND, v);
        cmp("echo2_rst", 10'h0, {2'h0, v});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            if (rows[i].a == ADDR_MODULE_CONFIG) begin
                wr(ADDR_MODULE_CONFIG_SHADOW, rows[i].d);
            end
            rd(rows[i].a, v);
            cmp("reg_rd", {2'h0, rows[i].e}, {2'h0, v});
        end
        cmp("io_exp", 10'h1, {9'h0, io_expansion_o});
        cmp("mem_exp", 10'h1, {9'h0, mem_expansion_o});
        cmp("mem_w", 10'h1, {9'h0, mem_width_o});
        // Idle mode must freeze the byte even against a legal write
        active_mode_i = 1'b0;
        wr_mc(8'h0A);
        rd(ADDR_MODULE_CONFIG, v);
        cmp("idle_hold", 10'h01F, {2'h0, v});
        active_mode_i = 1'b1;
        wr_mc(8'h0A);
        cmp("shadow_wr", 10'h1, {9'h0, shadow_wr_o});
        cmp("shadow_d", 10'h00A, {2'h0, shadow_data_o});
        cyc(1);
        cmp("shadow_end", 10'h0, {9'h0, shadow_wr_o});
        cmp("io_off", 10'h0, {9'h0, io_expansion_o});
        cmp("mem_8", 10'h0, {9'h0, mem_width_o});
        core_clk_en_i = 1'b1;
        cyc(4);
        cmp("clk_core", 10'h1, {9'h0, clock_out_o});
        wr_mc(8'h12);
        slow_clk_i = 1'b1;
        cyc(4);
        cmp("clk_slow", 10'h1, {9'h0, clock_out_o});
        slow_clk_i = 1'b0;
        cyc(4);
        cmp("clk_slow0", 10'h0, {9'h0, clock_out_o});
        // Clock out stays low while the pin is not an output
        clock_output_pin_is_output_i = 1'b0;
        slow_clk_i = 1'b1;
        cyc(4);
        cmp("clk_noout", 10'h0, {9'h0, clock_out_o});
        clock_output_pin_is_output_i = 1'b1;
        slow_clk_i = 1'b0;
        dev_env_i = 1'b1;
        cyc(1);
        cmp("dev_alloc", 10'h1, {9'h0, dev_alloc_o});
        cmp("dev_io", 10'h1, {9'h0, io_expansion_o});
        dev_env_i = 1'b0;
        cmp("wake_open", 10'h3, {8'h0, wake_open_o});
        wake_pin_i = 2'h1;
        cyc(4);
        cmp("wake_irq", 10'h1, {8'h0, wake_to_irq_o});
        wake_is_gpio_i = 2'h0;
        cyc(4);
        cmp("wake_nogpio", 10'h0, {8'h0, wake_to_irq_o});
        wake_is_gpio_i = 2'h3;
        wr(ADDR_EXT_IRQ_CONFIG, 8'h02);
        cyc(4);
        cmp("wake_block", 10'h0, {8'h0, wake_to_irq_o});
        alt_in_sel_i = 10'h2A5;
        cyc(1);
        cmp("alt_irq", 10'h2A5, alt_irq_en_o);
        // Both wake inputs get their interrupt function opened before the echo check
        wr(ADDR_EXT_IRQ_CONFIG, 8'h03);
        echo_in_pin_i = 10'h155;
        echo_out_gpio_i = 10'h3FE;
        cyc(4);
        cmp("echo_valid", 10'h2BE, echo_valid_o);
        cmp("echo_val", 10'h014, echo_val_o);
        do_reset(1'b0);
        rd(ADDR_MODULE_CONFIG, v);
        cmp("module_config_rst0", 10'h0, {2'h0, v});
        wr(ADDR_MODULE_CONFIG_SHADOW, v);
        rd(ADDR_ECHO_SECOND, v);
        cmp("echo2_rst0", 10'h0, {2'h0, v});
        summarize();
    end
endmodule : tb_top
`default_nettype wire
